// >>> verilog/ccs_pkg.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// shared constants and types of the clock state controller
package ccs_pkg;

    // clock and latency figures
    localparam int CLK_PERIOD_NS = 10;        // system clock period
    localparam int DS_EXIT_NS = 30000;        // deep sleep exit time, longest
    localparam int CNT_W = 12;                // exit timer width
    localparam logic [CNT_W-1:0] QS_EXIT_CYC = 12'h008;   // quick start to normal
    localparam logic [CNT_W-1:0] SG_EXIT_CYC = 12'h00a;   // stop grant to normal
    // longest time rounds down to whole cycles
    localparam logic [CNT_W-1:0] DS_EXIT_CYC = CNT_W'(DS_EXIT_NS / CLK_PERIOD_NS);

    // positions in the edge-detected event vector
    localparam int EV_NMI = 0;
    localparam int EV_MASKABLE_INTERRUPT_REQUEST = 1;
    localparam int EV_BUS_INIT = 2;
    localparam int EV_SINIT = 3;
    localparam int EV_RESET = 4;
    localparam int EV_FLUSH = 5;
    localparam int EV_SMI = 6;
    localparam int EV_W = 7;

    // positions in the pending / service vector
    localparam int PD_NMI = 0;
    localparam int PD_MASKABLE_INTERRUPT_REQUEST = 1;
    localparam int PD_SINIT = 2;
    localparam int PD_FLUSH = 3;
    localparam int PD_SMI = 4;
    localparam int PD_W = 5;

    // clock states, one-hot
    typedef enum logic [10:0] {
        ST_NORMAL = 11'h001,
        ST_AUTO_HALT = 11'h002,
        ST_STOP_GRANT = 11'h004,
        ST_QUICK_START = 11'h008,
        ST_SNOOP = 11'h010,
        ST_SLEEP = 11'h020,
        ST_DEEP_SLEEP = 11'h040,
        ST_EXIT_WAIT = 11'h080,
        ST_HALT_FLUSH = 11'h100,
        ST_HALT_SMM = 11'h200,
        ST_WAKE_WAIT = 11'h400
    } ccs_state_t;

    // rising edge of a vector of levels
    function automatic logic [EV_W-1:0] rise(input logic [EV_W-1:0] prev,
                                             input logic [EV_W-1:0] cur);
        rise = cur & ~prev;
    endfunction : rise

endpackage : ccs_pkg
`default_nettype wire

// >>> verilog/ccs_tmr_if.sv
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// link between the state machine and its latency timer
interface ccs_tmr_if;
    logic load;                          // start a new count
    logic [ccs_pkg::CNT_W-1:0] count;    // cycles until done
    logic done;                          // one-cycle pulse at the end

    modport ctrl (output load, output count, input done);
    modport tmr (input load, input count, output done);
endinterface : ccs_tmr_if
`default_nettype wire

// >>> verilog/ccs_exit_timer.sv
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// down counter: done is combinational, so a user registering it moves count cycles after load
module ccs_exit_timer #(
    parameter int WIDTH = ccs_pkg::CNT_W
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // control link
    ccs_tmr_if.tmr tmr
);

    // a counter narrower than four bits is rejected
    if (WIDTH < 4) begin : g_bad_width
        $error("ccs_exit_timer: WIDTH too small");
    end

    typedef struct packed {
        logic [WIDTH-1:0] cnt;   // cycles left
        logic busy;              // a count is running
    } ccs_tmr_st_t;

    ccs_tmr_st_t st_r;
    ccs_tmr_st_t st_nxt;

    // next-state: a new load restarts the count
    always_comb begin
        st_nxt = st_r;
        if (tmr.load) begin
            st_nxt.cnt = tmr.count;
            st_nxt.busy = 1'b1;
        end else if (st_r.busy) begin
            if (st_r.cnt <= WIDTH'(1)) begin
                st_nxt.busy = 1'b0;
                st_nxt.cnt = '0;
            end else begin
                st_nxt.cnt = st_r.cnt - WIDTH'(1);
            end
        end
    end

    // registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // last cycle of a count; a registered pulse would add one cycle to every exit
    assign tmr.done = st_r.busy && (st_r.cnt <= WIDTH'(1));

endmodule : ccs_exit_timer
`default_nettype wire

// >>> verilog/ccs_top.sv
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - strap grounded selects quick start, else stop grant
// - halt instruction moves normal into auto halt
// - halt break events return auto halt to normal
// - stop request in auto halt enters stop, acknowledges
// - stop release returns to auto halt, no halt cycle
// - system interrupt serviced in halt, may resume halt
// - cache flush in halt returns to halt silently
// - address mask and probe tracked during auto halt
// - stop grant snoops and latches one of each event
// - stop grant leaves on release or bus init, not on reset
// - after bus init, re-enter stop grant if requested
// - reset in stop states initialises, state kept
// - sleep only from stop grant, ignored elsewhere
// - quick start: priority snoops only, nothing latched
// - quick start exits on release or clock stop
// - snoops in idle states serviced, then return
// - sleep neither snoops nor latches; inputs held steady
// - clock stopped in sleep enters deep sleep
// - deep sleep exit completes within thirty microseconds
// - quick start exit eight clocks, stop grant ten
module ccs_top (
    // clock and reset of this logic
    input wire logic SYS_CLK_I,
    input wire logic RESETN_I,
    // power management requests from the core-logic controller
    input wire logic STOP_CLOCK_REQUEST_I,
    input wire logic SLEEP_REQUEST_I,
    input wire logic BUS_CLOCK_RUNNING_I,
    input wire logic STRAP_SELECT_LINE_I,
    // core events
    input wire logic HALT_INSTRUCTION_I,
    input wire logic SMM_EXIT_I,
    input wire logic SMM_RESUME_HALT_I,
    input wire logic FLUSH_DONE_I,
    // break and interrupt inputs
    input wire logic NONMASKABLE_INTERRUPT_I,
    input wire logic MASKABLE_INTERRUPT_REQUEST_I,
    input wire logic [1:0] LOCAL_INTERRUPT_LINES_I,
    input wire logic BUS_INIT_I,
    input wire logic BUS_INIT_DONE_I,
    input wire logic SOFT_INIT_I,
    input wire logic CPU_RESET_I,
    input wire logic CACHE_FLUSH_REQUEST_I,
    input wire logic SYSTEM_MGMT_INTERRUPT_I,
    // tracked levels
    input wire logic ADDR_BIT20_MASK_I,
    input wire logic PROBE_REQUEST_I,
    // snoop traffic
    input wire logic SNOOP_I,
    input wire logic PRIORITY_AGENT_REQUEST_I,
    input wire logic SNOOP_DONE_I,
    input wire logic BUS_IDLE_I,
    // state and bus cycle outputs
    output logic [10:0] STATE_O,
    output logic CORE_CLOCK_RUN_O,
    output logic STOP_GRANT_ACK_O,
    output logic HALT_CYCLE_O,
    output logic INIT_O,
    output logic QUICK_START_SEL_O,
    // latched events
    output logic [4:0] PENDING_O,
    output logic [4:0] SERVICE_O,
    // tracked levels
    output logic ADDR_BIT20_MASK_O,
    output logic PROBE_REQUEST_O
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        ccs_pkg::ccs_state_t state;            // present clock state
        ccs_pkg::ccs_state_t ret_state;        // where snoop / wake returns
        ccs_pkg::ccs_state_t exit_to;          // target after exit latency
        logic halt_origin;                     // stop state entered from halt
        logic quick_sel;                       // captured strap choice
        logic strap_done;                      // strap caught since reset
        logic bus_init_pend;                      // bus init taken from stop grant
        logic [ccs_pkg::EV_W-1:0] prev_ev;     // event levels one cycle ago
        logic [ccs_pkg::PD_W-1:0] pending;     // one latch per latchable event kind; bus init and reset have none
        logic [ccs_pkg::PD_W-1:0] service;     // pulse: hand latched events over
        logic ack;                             // stop grant acknowledge pulse
        logic halt_cyc;                        // halt bus cycle pulse
        logic init;                            // initialise pulse
        logic addr_bit20_mask;                            // recognised address mask level
        logic probe;                           // recognised probe level
    } ccs_st_t;

    ccs_st_t st_r;
    ccs_st_t st_nxt;

    ccs_tmr_if tmr_if ();   // link to the latency timer

    logic [ccs_pkg::EV_W-1:0] ev_lvl;   // present event levels
    logic [ccs_pkg::EV_W-1:0] ev_rise;  // events becoming active
    logic [ccs_pkg::PD_W-1:0] ev_latch; // latchable events rising
    logic halt_break;                   // break other than reset, flush or smi
    logic tmr_load;                     // start timer this cycle
    logic [ccs_pkg::CNT_W-1:0] tmr_count; // count loaded into the timer
    ccs_pkg::ccs_state_t stop_state;    // stop state picked by the strap

    ////////////////////////////////////////////////////////////////////////////
    // event decode

    // the local lines stand in for nmi and maskable_interrupt_request when wired that way
    always_comb begin
        ev_lvl = '0;
        ev_lvl[ccs_pkg::EV_NMI] = NONMASKABLE_INTERRUPT_I | LOCAL_INTERRUPT_LINES_I[1];
        ev_lvl[ccs_pkg::EV_MASKABLE_INTERRUPT_REQUEST] = MASKABLE_INTERRUPT_REQUEST_I | LOCAL_INTERRUPT_LINES_I[0];
        ev_lvl[ccs_pkg::EV_BUS_INIT] = BUS_INIT_I;
        ev_lvl[ccs_pkg::EV_SINIT] = SOFT_INIT_I;
        ev_lvl[ccs_pkg::EV_RESET] = CPU_RESET_I;
        ev_lvl[ccs_pkg::EV_FLUSH] = CACHE_FLUSH_REQUEST_I;
        ev_lvl[ccs_pkg::EV_SMI] = SYSTEM_MGMT_INTERRUPT_I;
        ev_rise = ccs_pkg::rise(st_r.prev_ev, ev_lvl);
        // only the latchable kinds, in pending order
        ev_latch = '0;
        ev_latch[ccs_pkg::PD_NMI] = ev_rise[ccs_pkg::EV_NMI];
        ev_latch[ccs_pkg::PD_MASKABLE_INTERRUPT_REQUEST] = ev_rise[ccs_pkg::EV_MASKABLE_INTERRUPT_REQUEST];
        ev_latch[ccs_pkg::PD_SINIT] = ev_rise[ccs_pkg::EV_SINIT];
        ev_latch[ccs_pkg::PD_FLUSH] = ev_rise[ccs_pkg::EV_FLUSH];
        ev_latch[ccs_pkg::PD_SMI] = ev_rise[ccs_pkg::EV_SMI];
        // flush and smi have their own halt service paths
        halt_break = ev_rise[ccs_pkg::EV_NMI] | ev_rise[ccs_pkg::EV_MASKABLE_INTERRUPT_REQUEST]
                   | ev_rise[ccs_pkg::EV_BUS_INIT] | ev_rise[ccs_pkg::EV_SINIT];
    end

    // the strap choice is fixed, so the stop target is just a mux
    assign stop_state = st_r.quick_sel ? ccs_pkg::ST_QUICK_START
                                       : ccs_pkg::ST_STOP_GRANT;

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        st_nxt = st_r;
        tmr_load = 1'b0;
        tmr_count = '0;
        st_nxt.prev_ev = ev_lvl;
        st_nxt.ack = 1'b0;
        st_nxt.halt_cyc = 1'b0;
        st_nxt.init = 1'b0;
        st_nxt.service = '0;

        // strap caught on the first cycle after either reset releases
        if (!st_r.strap_done || (st_r.prev_ev[ccs_pkg::EV_RESET] && !CPU_RESET_I)) begin
            st_nxt.quick_sel = ~STRAP_SELECT_LINE_I;
            st_nxt.strap_done = 1'b1;
        end

        case (st_r.state)
            // running: requests to idle, events pass straight to the core
            ccs_pkg::ST_NORMAL: begin
                st_nxt.addr_bit20_mask = ADDR_BIT20_MASK_I;
                st_nxt.probe = PROBE_REQUEST_I;
                if (ev_rise[ccs_pkg::EV_RESET]) begin
                    st_nxt.init = 1'b1;
                    st_nxt.bus_init_pend = 1'b0;
                end else if (st_r.bus_init_pend && BUS_INIT_DONE_I) begin
                    // bus init finished: go back to stop unless released
                    st_nxt.bus_init_pend = 1'b0;
                    if (STOP_CLOCK_REQUEST_I) begin
                        st_nxt.state = ccs_pkg::ST_STOP_GRANT;
                        st_nxt.ack = 1'b1;
                    end
                end else if (STOP_CLOCK_REQUEST_I && !st_r.bus_init_pend) begin
                    st_nxt.state = stop_state;
                    st_nxt.halt_origin = 1'b0;
                    st_nxt.ack = 1'b1;
                end else if (HALT_INSTRUCTION_I) begin
                    st_nxt.state = ccs_pkg::ST_AUTO_HALT;
                    st_nxt.halt_cyc = 1'b1;
                end
                // sleep request has no meaning here and is dropped
            end

            // halted by software
            ccs_pkg::ST_AUTO_HALT: begin
                st_nxt.addr_bit20_mask = ADDR_BIT20_MASK_I;
                st_nxt.probe = PROBE_REQUEST_I;
                if (ev_rise[ccs_pkg::EV_RESET]) begin
                    st_nxt.state = ccs_pkg::ST_NORMAL;
                    st_nxt.init = 1'b1;
                end else if (ev_rise[ccs_pkg::EV_SMI]) begin
                    st_nxt.state = ccs_pkg::ST_HALT_SMM;
                end else if (ev_rise[ccs_pkg::EV_FLUSH]) begin
                    st_nxt.state = ccs_pkg::ST_HALT_FLUSH;
                end else if (halt_break) begin
                    st_nxt.state = ccs_pkg::ST_NORMAL;
                end else if (STOP_CLOCK_REQUEST_I) begin
                    st_nxt.state = stop_state;
                    st_nxt.halt_origin = 1'b1;
                    st_nxt.ack = 1'b1;
                end else if (SNOOP_I) begin
                    st_nxt.ret_state = ccs_pkg::ST_AUTO_HALT;
                    st_nxt.state = ccs_pkg::ST_SNOOP;
                end
                // sleep request is ignored in auto halt
            end

            // management handler running out of auto halt
            ccs_pkg::ST_HALT_SMM: begin
                if (SMM_EXIT_I) begin
                    // resuming in halt issues no fresh halt cycle
                    st_nxt.state = SMM_RESUME_HALT_I ? ccs_pkg::ST_AUTO_HALT
                                                     : ccs_pkg::ST_NORMAL;
                end
            end

            // both cache levels being flushed out of auto halt
            ccs_pkg::ST_HALT_FLUSH: begin
                if (FLUSH_DONE_I) begin
                    st_nxt.state = ccs_pkg::ST_AUTO_HALT;
                end
            end

            // stop grant: snoops served, events latched once each
            ccs_pkg::ST_STOP_GRANT: begin
                st_nxt.pending = st_r.pending | ev_latch;
                if (ev_rise[ccs_pkg::EV_RESET]) begin
                    // initialise now, stay stopped until released
                    st_nxt.init = 1'b1;
                    st_nxt.pending = '0;
                    st_nxt.halt_origin = 1'b0;
                end else if (ev_rise[ccs_pkg::EV_BUS_INIT]) begin
                    st_nxt.state = ccs_pkg::ST_NORMAL;
                    st_nxt.bus_init_pend = STOP_CLOCK_REQUEST_I;
                    st_nxt.service = st_nxt.pending;
                    st_nxt.pending = '0;
                end else if (!STOP_CLOCK_REQUEST_I) begin
                    st_nxt.state = ccs_pkg::ST_EXIT_WAIT;
                    st_nxt.exit_to = st_r.halt_origin ? ccs_pkg::ST_AUTO_HALT
                                                      : ccs_pkg::ST_NORMAL;
                    tmr_load = 1'b1;
                    tmr_count = ccs_pkg::SG_EXIT_CYC;
                end else if (SLEEP_REQUEST_I) begin
                    st_nxt.state = ccs_pkg::ST_SLEEP;
                end else if (SNOOP_I) begin
                    st_nxt.ret_state = ccs_pkg::ST_STOP_GRANT;
                    st_nxt.state = ccs_pkg::ST_SNOOP;
                end
            end

            // quick start: nothing but priority snoops, reset, release, clock stop
            ccs_pkg::ST_QUICK_START: begin
                if (ev_rise[ccs_pkg::EV_RESET]) begin
                    st_nxt.init = 1'b1;
                    st_nxt.halt_origin = 1'b0;
                end else if (!BUS_CLOCK_RUNNING_I) begin
                    st_nxt.ret_state = ccs_pkg::ST_QUICK_START;
                    st_nxt.state = ccs_pkg::ST_DEEP_SLEEP;
                end else if (!STOP_CLOCK_REQUEST_I) begin
                    st_nxt.state = ccs_pkg::ST_EXIT_WAIT;
                    st_nxt.exit_to = st_r.halt_origin ? ccs_pkg::ST_AUTO_HALT
                                                      : ccs_pkg::ST_NORMAL;
                    tmr_load = 1'b1;
                    tmr_count = ccs_pkg::QS_EXIT_CYC;
                end else if (SNOOP_I && PRIORITY_AGENT_REQUEST_I) begin
                    st_nxt.ret_state = ccs_pkg::ST_QUICK_START;
                    st_nxt.state = ccs_pkg::ST_SNOOP;
                end
                // interrupts, flush and bus init are not acted on
            end

            // snoop in service; stop grant keeps latching meanwhile
            ccs_pkg::ST_SNOOP: begin
                if (st_r.ret_state == ccs_pkg::ST_STOP_GRANT) begin
                    st_nxt.pending = st_r.pending | ev_latch;
                end
                if (SNOOP_DONE_I && BUS_IDLE_I) begin
                    st_nxt.state = st_r.ret_state;
                end
            end

            // sleep: no snoop, no latch, inputs held by the controller
            ccs_pkg::ST_SLEEP: begin
                if (ev_rise[ccs_pkg::EV_RESET]) begin
                    st_nxt.init = 1'b1;
                    st_nxt.pending = '0;
                end else if (!BUS_CLOCK_RUNNING_I) begin
                    st_nxt.ret_state = ccs_pkg::ST_SLEEP;
                    st_nxt.state = ccs_pkg::ST_DEEP_SLEEP;
                end else if (!SLEEP_REQUEST_I) begin
                    st_nxt.state = ccs_pkg::ST_STOP_GRANT;
                end
                // the reset branch relies on the controller dropping both requests
            end

            // clock gone: wait for it to return
            ccs_pkg::ST_DEEP_SLEEP: begin
                if (BUS_CLOCK_RUNNING_I) begin
                    st_nxt.state = ccs_pkg::ST_WAKE_WAIT;
                    tmr_load = 1'b1;
                    tmr_count = ccs_pkg::DS_EXIT_CYC;
                end
            end

            // lock time after the clock restarts
            ccs_pkg::ST_WAKE_WAIT: begin
                if (!BUS_CLOCK_RUNNING_I) begin
                    st_nxt.state = ccs_pkg::ST_DEEP_SLEEP;
                end else if (tmr_if.done) begin
                    st_nxt.state = st_r.ret_state;
                end
            end

            // counting out the exit latency of a stop state
            ccs_pkg::ST_EXIT_WAIT: begin
                if (tmr_if.done) begin
                    st_nxt.state = st_r.exit_to;
                    st_nxt.halt_origin = 1'b0;
                    // halt return issues no new halt cycle
                    if (st_r.exit_to == ccs_pkg::ST_NORMAL) begin
                        st_nxt.service = st_r.pending;
                        st_nxt.pending = '0;
                    end
                end
            end

            // an unknown code falls back to normal
            default: begin
                st_nxt.state = ccs_pkg::ST_NORMAL;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    // synchronous reset puts every field at a constant
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I) begin
            st_r <= '0;
            st_r.state <= ccs_pkg::ST_NORMAL;
            st_r.ret_state <= ccs_pkg::ST_NORMAL;
            st_r.exit_to <= ccs_pkg::ST_NORMAL;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // latency timer

    assign tmr_if.load = tmr_load;
    assign tmr_if.count = tmr_count;

    ccs_exit_timer #(
        .WIDTH(ccs_pkg::CNT_W)
    ) u_exit_timer (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RESETN_I),
        .tmr(tmr_if)
    );

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all from registers

    assign STATE_O = st_r.state;
    // the core runs while executing, servicing an smi or flush from halt, or serving a snoop
    assign CORE_CLOCK_RUN_O = (st_r.state == ccs_pkg::ST_NORMAL)
                            | (st_r.state == ccs_pkg::ST_HALT_SMM)
                            | (st_r.state == ccs_pkg::ST_HALT_FLUSH)
                            | (st_r.state == ccs_pkg::ST_SNOOP);
    assign STOP_GRANT_ACK_O = st_r.ack;
    assign HALT_CYCLE_O = st_r.halt_cyc;
    assign INIT_O = st_r.init;
    assign QUICK_START_SEL_O = st_r.quick_sel;
    assign PENDING_O = st_r.pending;
    assign SERVICE_O = st_r.service;
    assign ADDR_BIT20_MASK_O = st_r.addr_bit20_mask;
    assign PROBE_REQUEST_O = st_r.probe;

endmodule : ccs_top
`default_nettype wire

// >>> dv/ccs_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// watches the top ports only; the sync reset gates every check
module ccs_monitor (
    input wire logic SYS_CLK_I,
    input wire logic RESETN_I,
    input wire logic STOP_CLOCK_REQUEST_I,
    input wire logic BUS_CLOCK_RUNNING_I,
    input wire logic PRIORITY_AGENT_REQUEST_I,
    input wire logic ADDR_BIT20_MASK_I,
    input wire logic [10:0] STATE_O,
    input wire logic HALT_CYCLE_O,
    input wire logic STOP_GRANT_ACK_O,
    input wire logic QUICK_START_SEL_O,
    input wire logic ADDR_BIT20_MASK_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!RESETN_I);
    AST_HALT: assert property (HALT_CYCLE_O |-> STATE_O == ccs_pkg::ST_AUTO_HALT
        && $past(STATE_O) == ccs_pkg::ST_NORMAL) else $error("halt cycle off normal entry");
    AST_ACK: assert property (STOP_GRANT_ACK_O |-> STATE_O inside
        {ccs_pkg::ST_STOP_GRANT, ccs_pkg::ST_QUICK_START}) else $error("ack outside stop");
    AST_STRAP: assert property (STATE_O == ccs_pkg::ST_QUICK_START |-> QUICK_START_SEL_O)
        else $error("quick start in stop grant mode");
    AST_SLEEP: assert property ($rose(STATE_O == ccs_pkg::ST_SLEEP) |-> $past(STATE_O)
        inside {ccs_pkg::ST_STOP_GRANT, ccs_pkg::ST_WAKE_WAIT}) else $error("bad sleep entry");
    AST_QS_EXIT: assert property ($rose(STATE_O == ccs_pkg::ST_EXIT_WAIT) && QUICK_START_SEL_O
        |-> ##7 STATE_O == ccs_pkg::ST_EXIT_WAIT ##1 STATE_O != ccs_pkg::ST_EXIT_WAIT)
        else $error("quick start exit not 8 cycles");
    AST_SG_EXIT: assert property ($rose(STATE_O == ccs_pkg::ST_EXIT_WAIT) && !QUICK_START_SEL_O
        |-> ##9 STATE_O == ccs_pkg::ST_EXIT_WAIT ##1 STATE_O != ccs_pkg::ST_EXIT_WAIT)
        else $error("stop grant exit not 10 cycles");
    AST_QS_HOLD: assert property (STATE_O == ccs_pkg::ST_QUICK_START && STOP_CLOCK_REQUEST_I
        && BUS_CLOCK_RUNNING_I && !PRIORITY_AGENT_REQUEST_I |=> STATE_O == ccs_pkg::ST_QUICK_START)
        else $error("quick start left while held");
    AST_TRACK: assert property (STATE_O == ccs_pkg::ST_AUTO_HALT
        && $past(STATE_O) == ccs_pkg::ST_AUTO_HALT |-> ADDR_BIT20_MASK_O == $past(ADDR_BIT20_MASK_I))
        else $error("mask not tracked in halt");
endmodule : ccs_monitor
`default_nettype wire

// >>> dv/ccs_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
// core-logic side: turns bench commands into power requests
module ccs_ctrl_model (
    input wire logic cmd_stop_i,
    input wire logic cmd_sleep_i,
    input wire logic cmd_clk_i,
    input wire logic cpu_reset_i,
    input wire logic [10:0] state_i,
    output logic stop_o,
    output logic sleep_o,
    output logic clk_run_o
);
    // reset while asleep drops both requests at once, else init goes wrong
    logic drop;
    assign drop = cpu_reset_i && state_i == ccs_pkg::ST_SLEEP;
    assign stop_o = cmd_stop_i && !drop;
    assign sleep_o = cmd_sleep_i && !drop;
    // bus clock follows the bench command directly, whatever the state
    assign clk_run_o = cmd_clk_i;
    // no serial interrupt messages are ever sent; bench holds the rest
endmodule : ccs_ctrl_model
`default_nettype wire

// >>> dv/ccs_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module ccs_top_tb_top;
    // bench drivers, launched by nba at the rising edge
    logic clk = 0, rstn = 0, strap = 1, halt = 0, cs = 0, csl = 0, cck = 1, crst = 0, a20 = 0;
    logic [3:0] brk = '0; // nmi, maskable_interrupt_request, bus init, soft init
    logic [12:0] ev = '0; // remaining event, snoop and probe inputs
    logic stop, slp, crun, ack, hcy, ini, qsel, a20o, ccr, pro;
    logic [10:0] st;
    logic [4:0] pend, svc;
    int mismatches = 0, num_checks = 0, cyc = 0, n = 0;
    initial forever #5 clk = ~clk;
    ccs_ctrl_model ctl_u (.cmd_stop_i(cs), .cmd_sleep_i(csl), .cmd_clk_i(cck),
        .cpu_reset_i(crst), .state_i(st), .stop_o(stop), .sleep_o(slp), .clk_run_o(crun));
    ccs_top dut_u (.SYS_CLK_I(clk), .RESETN_I(rstn), .STOP_CLOCK_REQUEST_I(stop),
        .SLEEP_REQUEST_I(slp), .BUS_CLOCK_RUNNING_I(crun), .STRAP_SELECT_LINE_I(strap),
        .HALT_INSTRUCTION_I(halt), .SMM_EXIT_I(ev[0]), .SMM_RESUME_HALT_I(ev[1]),
        .FLUSH_DONE_I(ev[2]), .NONMASKABLE_INTERRUPT_I(brk[0]), .MASKABLE_INTERRUPT_REQUEST_I(brk[1]),
        .LOCAL_INTERRUPT_LINES_I(ev[4:3]), .BUS_INIT_I(brk[2]), .BUS_INIT_DONE_I(ev[5]),
        .SOFT_INIT_I(brk[3]), .CPU_RESET_I(crst), .CACHE_FLUSH_REQUEST_I(ev[6]),
        .SYSTEM_MGMT_INTERRUPT_I(ev[7]), .ADDR_BIT20_MASK_I(a20), .PROBE_REQUEST_I(ev[12]),
        .SNOOP_I(ev[8]), .PRIORITY_AGENT_REQUEST_I(ev[9]), .SNOOP_DONE_I(ev[10]),
        .BUS_IDLE_I(ev[11]), .STATE_O(st), .CORE_CLOCK_RUN_O(ccr), .STOP_GRANT_ACK_O(ack),
        .HALT_CYCLE_O(hcy), .INIT_O(ini), .QUICK_START_SEL_O(qsel), .PENDING_O(pend),
        .SERVICE_O(svc), .ADDR_BIT20_MASK_O(a20o), .PROBE_REQUEST_O(pro));
    task automatic chk(input logic [10:0] g, input logic [10:0] e);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %0t %h %h", $time, g, e);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict
    // hang guard, well above the deep sleep wake time
    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            mismatches++;
            print_verdict();
        end
    end
    initial begin
        n = $urandom(46283);
        repeat (3) @(posedge clk);
        rstn <= 1;
        @(posedge clk) strap <= 0; // strap moves after capture, must not matter
        @(posedge clk) csl <= 1;
        @(posedge clk) csl <= 0;
        #1 chk(st, ccs_pkg::ST_NORMAL);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) halt <= 1;
            @(posedge clk) halt <= 0;
            #1 chk(st, ccs_pkg::ST_AUTO_HALT);
            chk(hcy, 1);
            @(posedge clk) a20 <= 1'($urandom);
            ev[12] <= 1'($urandom);
            @(posedge clk) brk[i] <= 1;
            @(posedge clk) brk <= '0;
            #1 chk(st, ccs_pkg::ST_NORMAL);
            chk({a20o, pro}, {a20, ev[12]});
        end
        @(posedge clk) cs <= 1;
        @(posedge clk) #1 chk(st, ccs_pkg::ST_STOP_GRANT);
        chk(ack, 1);
        repeat (2) begin
            @(posedge clk) brk <= 4'h3;
            @(posedge clk) brk <= '0;
        end
        @(posedge clk) csl <= 1;
        #1 chk(pend, 5'h03);
        @(posedge clk) #1 chk(st, ccs_pkg::ST_SLEEP);
        @(posedge clk) cck <= 0;
        @(posedge clk) #1 chk(st, ccs_pkg::ST_DEEP_SLEEP);
        chk(ccr, 0);
        @(posedge clk) cck <= 1;
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (st !== ccs_pkg::ST_SLEEP && n < 4000);
        chk(n <= 3001, 1);
        @(posedge clk) csl <= 0;
        @(posedge clk) #1 chk(st, ccs_pkg::ST_STOP_GRANT);
        chk(pend, 5'h03);
        @(posedge clk) cs <= 0;
        @(posedge clk) repeat (10) @(posedge clk);
        #1 chk(st, ccs_pkg::ST_NORMAL);
        chk(svc, 5'h03);
        @(posedge clk) rstn <= 0;
        @(posedge clk) rstn <= 1;
        @(posedge clk) @(posedge clk) cs <= 1;
        @(posedge clk) #1 chk(st, ccs_pkg::ST_QUICK_START);
        chk(qsel, 1);
        @(posedge clk) ev[11:8] <= 4'hf;
        @(posedge clk) ev[9:8] <= '0;
        #1 chk(st, ccs_pkg::ST_SNOOP);
        chk(ccr, 1);
        @(posedge clk) ev[11:10] <= '0;
        #1 chk(st, ccs_pkg::ST_QUICK_START);
        @(posedge clk) crst <= 1;
        @(posedge clk) crst <= 0;
        #1 chk(ini, 1);
        @(posedge clk) cs <= 0;
        #1 chk(st, ccs_pkg::ST_QUICK_START);
        @(posedge clk) repeat (8) @(posedge clk);
        #1 chk(st, ccs_pkg::ST_NORMAL);
        print_verdict();
    end
endmodule : ccs_top_tb_top
bind ccs_top ccs_monitor mon_u (.*);
`default_nettype wire
